// File: ldac_pkg.sv
// package of constants and types for the loop dac serial loader
package ldac_pkg;
   localparam int unsigned  MCLK_HZ        = 100_000_000;
   localparam int unsigned  NORM_BITS      = 16;
   localparam int unsigned  ALARM_BITS     = 17;
   localparam int unsigned  CNT_BITS       = 5;            // modulo 32 pulse count
   localparam logic [4:0]   NORM_MAX_CNT   = 5'h10;        // 0..16 normal, 17..31 alarm
   localparam logic [4:0]   CNT_RESET      = 5'h00;
   localparam logic [16:0]  LATCH_RESET    = 17'h00000;
   localparam logic [16:0]  ALARM_LO_CODE  = 17'h03800;    // 3.5 mA advisory floor
   localparam logic [16:0]  ALARM_HI_CODE  = 17'h18000;    // 24 mA advisory ceiling
   localparam int unsigned  NORM_STEP_PA   = 244141;       // 16 mA / 65536, in picoamps
   localparam int unsigned  ALARM_STEP_PA  = 244141;       // 32 mA / 131072, in picoamps
   localparam logic [31:0]  NORM_ZERO_NA   = 32'h003d0900; // 4 mA offset in nA (4,000,000)
   localparam int unsigned  MOD_DIV        = 4;            // modulator rate divider
   localparam logic [1:0]   MOD_DIV_LAST   = 2'(MOD_DIV - 1);

   // loaded code as seen by the converter
   typedef struct packed {
      logic        alarm;
      logic [16:0] code;
   } ldac_latch_s;

   // host pins, raw or after synchronisation
   typedef struct packed {
      logic clk;
      logic data;
      logic load;
   } ldac_pins_s;
endpackage

// File: ldac_sync.sv
// two-flop synchroniser with rising edge detect for host pins
`timescale 1ns/1ns
module ldac_sync
   import ldac_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // raw and synchronised pins
   input  wire ldac_pins_s  pins_raw,
   output ldac_pins_s       pins_sync,
   output logic             clk_rise,
   output logic             load_rise
);
   ldac_pins_s stage1;
   ldac_pins_s stage2;
   ldac_pins_s stage3;
   logic [2:0] primed;

   // capture chain, stage1 read only by stage2
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= pins_raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // edges ignored until the chain holds real pin levels, so an idle-high strobe gives no false rise
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         primed <= 3'h0;
      end else begin
         primed <= {primed[1:0], 1'b1};
      end
   end

   // edges seen in the same cycle the second flop takes the new level, against the third flop
   assign pins_sync = stage2;
   assign clk_rise  = primed[2] & stage2.clk & ~stage3.clk;
   assign load_rise = primed[2] & stage2.load & ~stage3.load;
endmodule

// File: ldac_loader.sv
// serial loader, dac latch and modulator gate of the loop dac
`timescale 1ns/1ns
module ldac_loader
   import ldac_pkg::*;
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          nrst,
   // host serial pins
   input  wire logic          serial_clk,
   input  wire logic          serial_data,
   input  wire logic          load_strobe,
   // reference overload sense from the high reference output
   input  wire logic          high_reference_overload,
   // converter side
   output ldac_latch_s        dac_latch,
   output logic [31:0]        loop_current_na,
   output logic               mod_enable,
   output logic               osc_running,
   output logic               mod_tick,
   output logic               alarm_out_of_range
);
   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisation

   logic        rst_meta;
   logic        rst_n;
   ldac_pins_s  pins_raw;
   ldac_pins_s  pins_sync;
   logic        clk_rise;
   logic        load_rise;
   logic        ovl_meta;
   logic        ovl_sync;

   // async assert, synchronous release
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign pins_raw = '{clk: serial_clk, data: serial_data, load: load_strobe};

   ldac_sync u_sync (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .pins_raw  (pins_raw),
      .pins_sync (pins_sync),
      .clk_rise  (clk_rise),
      .load_rise (load_rise)
   );

   // overload sense synchroniser
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovl_meta <= 1'b0;
         ovl_sync <= 1'b0;
      end else begin
         ovl_meta <= high_reference_overload;
         ovl_sync <= ovl_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state machine: running or held in overload reset

   typedef enum logic [1:0] {
      LDAC_RUN = 2'b01,
      LDAC_POR = 2'b10
   } ldac_state_e;

   ldac_state_e state;
   ldac_state_e next_state;

   // overload enters reset, recovery when the load goes away
   always_comb begin
      next_state = state;
      case (state)
         LDAC_RUN: begin
            if (ovl_sync) begin
               next_state = LDAC_POR;
            end
         end
         LDAC_POR: begin
            if (!ovl_sync) begin
               next_state = LDAC_RUN;
            end
         end
         default: begin
            next_state = LDAC_POR;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= LDAC_POR;
      end else begin
         state <= next_state;
      end
   end

   logic por_active;
   assign por_active = (state != LDAC_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // shift register and pulse counter

   logic [16:0]          shift_reg;
   logic [CNT_BITS-1:0]  pulse_cnt;

   // msb first shift, sampled on serial clock rise, last 17 bits kept
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= LATCH_RESET;
      end else if (clk_rise) begin
         shift_reg <= {shift_reg[15:0], pins_sync.data};
      end
   end

   // modulo 32 count, cleared by overload, restarted by strobe (at 1 if a clock rise coincides)
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt <= CNT_RESET;
      end else if (por_active) begin
         pulse_cnt <= CNT_RESET;
      end else if (load_rise) begin
         pulse_cnt <= clk_rise ? CNT_BITS'(1) : CNT_RESET;
      end else if (clk_rise) begin
         pulse_cnt <= pulse_cnt + CNT_BITS'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dac latch transfer

   logic alarm_sel;
   assign alarm_sel = (pulse_cnt > NORM_MAX_CNT);

   // parallel copy on strobe rise, cleared in overload
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dac_latch <= '{alarm: 1'b0, code: LATCH_RESET};
      end else if (por_active) begin
         dac_latch <= '{alarm: 1'b0, code: LATCH_RESET};
      end else if (load_rise) begin
         if (alarm_sel) begin
            dac_latch <= '{alarm: 1'b1, code: shift_reg};
         end else begin
            dac_latch <= '{alarm: 1'b0, code: {1'b0, shift_reg[15:0]}};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // code to current mapping and range flag

   // nominal loop current in nA for a latched code
   function automatic logic [31:0] code_to_na(input ldac_latch_s l);
      logic [47:0] prod;
      prod = 48'(l.code) * 48'(l.alarm ? ALARM_STEP_PA : NORM_STEP_PA);
      if (l.alarm) begin
         code_to_na = 32'(prod / 48'd1000);
      end else begin
         code_to_na = NORM_ZERO_NA + 32'(prod / 48'd1000);
      end
   endfunction

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         loop_current_na    <= 32'h00000000;
         alarm_out_of_range <= 1'b0;
      end else begin
         loop_current_na    <= code_to_na(dac_latch);
         alarm_out_of_range <= dac_latch.alarm &&
                               ((dac_latch.code < ALARM_LO_CODE) ||
                                (dac_latch.code > ALARM_HI_CODE));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // modulator oscillator enable divider

   logic [1:0] mod_div;

   // oscillator stopped and modulator off during overload
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mod_div     <= 2'h0;
         mod_tick    <= 1'b0;
         mod_enable  <= 1'b0;
         osc_running <= 1'b0;
      end else begin
         mod_enable  <= ~por_active;
         osc_running <= ~por_active;
         if (por_active) begin
            mod_div  <= 2'h0;
            mod_tick <= 1'b0;
         end else begin
            mod_div  <= (mod_div == MOD_DIV_LAST) ? 2'h0 : mod_div + 2'h1;
            mod_tick <= (mod_div == MOD_DIV_LAST);
         end
      end
   end
endmodule

// File: ldac_host_model.sv
// host serial port model driving clock, data and strobe
`timescale 1ns/1ns
module ldac_host_model (
   // pins toward the loader
   output logic sclk,
   output logic sdata,
   output logic strobe
);
   // line polarity, set high only where inverting isolators sit between host and loader
   localparam logic LINE_INV = 1'b0;
   logic clk_q;
   logic data_q;
   logic strobe_q;
   // host levels pre-inverted so the loader sees true polarity
   assign sclk   = clk_q ^ LINE_INV;
   assign sdata  = data_q ^ LINE_INV;
   assign strobe = strobe_q ^ LINE_INV;
   // idle pins: clock still, strobe high
   initial begin
      clk_q = 1'b0;
      data_q = 1'b0;
      strobe_q = 1'b1;
   end
   // n bits msb first at 80 ns per clock, then commit
   task automatic send(input logic [31:0] w, input int n);
      strobe_q = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         data_q = w[i];
         #40 clk_q = 1'b1;
         #40 clk_q = 1'b0;
      end
      data_q = ~data_q; // released line shows no stale bit
      #80 strobe_q = 1'b1;
      #80;
   endtask
endmodule

// File: ldac_loader_sva.sv
// assertions on the ports of the loop dac serial loader
`timescale 1ns/1ns
module ldac_loader_sva
   import ldac_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        nrst,
   // host pins
   input wire logic        serial_clk,
   input wire logic        serial_data,
   input wire logic        load_strobe,
   input wire logic        high_reference_overload,
   // converter side
   input wire ldac_latch_s dac_latch,
   input wire logic [31:0] loop_current_na,
   input wire logic        mod_enable,
   input wire logic        osc_running,
   input wire logic        mod_tick,
   input wire logic        alarm_out_of_range
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic        strobe_q;
   logic [3:0]  strobe_age;
   logic [31:0] exp_na;
   logic        exp_oor;
   // cycles since the last strobe rise, saturating
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strobe_q <= 1'b0;
         strobe_age <= 4'hf;
      end else begin
         strobe_q <= load_strobe;
         if (load_strobe && !strobe_q) strobe_age <= 4'h0;
         else if (strobe_age != 4'hf) strobe_age <= strobe_age + 4'h1;
      end
   end
   // nominal current and range flag of the held code
   always_comb begin
      exp_na = (dac_latch.alarm ? 32'h0 : NORM_ZERO_NA)
         + 32'((64'(dac_latch.code) * 64'(NORM_STEP_PA)) / 64'h3e8);
      exp_oor = dac_latch.alarm && (dac_latch.code < ALARM_LO_CODE
         || dac_latch.code > ALARM_HI_CODE);
   end
   sequence s_held;
      mod_enable [*3] ##0 $stable(dac_latch);
   endsequence
   sequence s_ovl;
      high_reference_overload [*5];
   endsequence
   property p_norm;
      !dac_latch.alarm |-> !dac_latch.code[16];
   endproperty
   property p_ovl;
      s_ovl |-> dac_latch == LATCH_RESET && !mod_enable && !osc_running;
   endproperty
   property p_hold;
      $changed(dac_latch) |-> strobe_age <= 4'h6 || dac_latch == LATCH_RESET;
   endproperty
   property p_cur;
      s_held |-> loop_current_na == exp_na;
   endproperty
   property p_oor;
      s_held |-> alarm_out_of_range == exp_oor;
   endproperty
   property p_tick;
      mod_tick && mod_enable |=> !mod_tick [*3] ##1 (mod_tick || !mod_enable);
   endproperty
   property p_osc;
      !osc_running |-> !mod_enable && !mod_tick;
   endproperty
   property p_run;
      !high_reference_overload [*8] |-> mod_enable;
   endproperty
   a_norm: assert property (p_norm) else $error("normal code bit 16 set");
   a_ovl: assert property (p_ovl) else $error("overload not cleared");
   a_hold: assert property (p_hold) else $error("latch moved without strobe");
   a_cur: assert property (p_cur) else $error("current wrong");
   a_oor: assert property (p_oor) else $error("range flag wrong");
   a_tick: assert property (p_tick) else $error("tick spacing wrong");
   a_osc: assert property (p_osc) else $error("modulator active with oscillator stopped");
   a_run: assert property (p_run) else $error("no restart after overload");
endmodule
bind ldac_loader ldac_loader_sva chk (.mclk, .nrst, .serial_clk, .serial_data, .load_strobe,
   .high_reference_overload, .dac_latch, .loop_current_na, .mod_enable, .osc_running,
   .mod_tick, .alarm_out_of_range);

// File: tb.sv
// self-checking bench for the loop dac serial loader
`timescale 1ns/1ns
module tb;
   import ldac_pkg::*;
   logic        mclk;
   logic        nrst;
   logic        ovl;
   logic        sclk;
   logic        sdata;
   logic        strobe;
   ldac_latch_s latch;
   logic [31:0] cur;
   logic        mod_en;
   logic        osc_on;
   logic        oor;
   logic        tick;
   int          failures;
   int          check_count;
   ldac_host_model host (.sclk(sclk), .sdata(sdata), .strobe(strobe));
   ldac_loader dut (.mclk(mclk), .nrst(nrst), .serial_clk(sclk), .serial_data(sdata),
      .load_strobe(strobe), .high_reference_overload(ovl), .dac_latch(latch),
      .loop_current_na(cur), .mod_enable(mod_en), .osc_running(osc_on), .mod_tick(tick),
      .alarm_out_of_range(oor));
   // compare helpers
   task automatic chk_latch(input ldac_latch_s got, input ldac_latch_s exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t latch %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t value %h want %h", $time, got, exp);
      end
   endtask
   // table of clock counts, words and latched results
   task automatic t_codes;
      // alarm codes in the 3.5 to 24 mA band, two probes outside it on purpose
      int          n[6] = '{16, 24, 17, 17, 31, 32};
      logic [31:0] w[6] = '{32'hb26d, 32'hfe3c00, 32'h18000, 32'h37ff, 32'h7fffffff, 32'h12345678};
      ldac_latch_s e[6] = '{18'h0b26d, 18'h23c00, 18'h38000, 18'h237ff, 18'h3ffff, 18'h05678};
      logic        r;
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk);
         #3 host.send(w[i], n[i]);
         r = e[i].alarm && (e[i].code < ALARM_LO_CODE || e[i].code > ALARM_HI_CODE);
         chk_latch(latch, e[i]);
         chk_val(cur, (e[i].alarm ? 32'h0 : 32'h3d0900) + 32'((64'(e[i].code) * 64'h3b9ad) / 64'h3e8));
         chk_val({31'h0, oor}, {31'h0, r});
      end
   endtask
   // overload clears and blocks the latch, then recovery
   task automatic t_overload;
      int ticks;
      @(posedge mclk);
      ovl <= 1'b1;
      #3 host.send(32'hffff, 16);
      chk_latch(latch, 18'h0);
      chk_val({30'h0, mod_en, osc_on}, 32'h0);
      @(posedge mclk);
      ovl <= 1'b0;
      repeat (12) @(posedge mclk);
      #3 host.send(32'h0ffff, 16);
      chk_val({30'h0, mod_en, osc_on}, 32'h3);
      chk_latch(latch, 18'h0ffff);
      // modulator ticks once per divider period while running
      ticks = 0;
      repeat (40) begin
         #10;
         if (tick === 1'b1) ticks++;
      end
      chk_val(32'(ticks), 32'(40 / MOD_DIV));
   endtask
   // verdict
   task automatic close_out;
      if (failures == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      failures = 0;
      check_count = 0;
      nrst = 1'b0;
      ovl = 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      repeat (12) @(posedge mclk);
      t_codes;
      t_overload;
      close_out;
   end
   // hang guard
   initial begin
      #200000;
      failures++;
      close_out;
   end
endmodule
